// ---- hw/charger_regs_defs.vh ----
`ifndef CHARGER_REGS_DEFS_VH
`define CHARGER_REGS_DEFS_VH

// Register offsets on the control bus
`define OFS_CHARGE_EVENT_MASK 8'h0B
`define OFS_THERMAL_TIMEOUT_MASK 8'h0C
`define OFS_BOOST_EVENT_MASK 8'h0D
`define OFS_CHARGE_VOLTAGE_SET 8'h0E
`define OFS_CHARGE_CURRENT_SET 8'h0F

// Field positions, charge event mask
`define BIT_INPUT_LOW 4
`define BIT_INPUT_HIGH 3
`define BIT_BATTERY_REMOVED 2
`define BIT_BUCK_OVERVOLTAGE 1
`define BIT_CHARGE_STATE_CHANGE 0

// Field positions, thermal and timeout mask
`define BIT_BATTERY_HOT 7
`define BIT_BATTERY_WARM 6
`define BIT_BATTERY_CHILLY 5
`define BIT_BATTERY_COLD 4
`define BIT_WATCHDOG_TIMEOUT 3
`define BIT_USB_TIMEOUT 2
`define BIT_CHARGE_TIMEOUT 1

// Field positions, setpoints
`define EOC_MSB 6
`define EOC_LSB 4
`define CHARGE_CURRENT_CODE_MSB 3
`define CHARGE_CURRENT_CODE_LSB 0
`define VSET_MSB 5
`define VSET_LSB 0

// Reset values of the stored fields
`define RST_CHARGE_EVENT_MASK 5'h00
`define RST_THERMAL_TIMEOUT_MASK 7'h07
`define RST_BOOST_EVENT_MASK 4'hF
`define RST_VOLTAGE_CODE 6'h0C
`define RST_EOC_CODE 3'h2
`define RST_CHARGE_CURRENT_CODE_CODE 4'h6

// Setpoint scaling
`define VSET_TOP_CODE 6'h30
`define VSET_BASE_MV 13'h0CE4
`define VSET_STEP_MV 13'h0019
`define EOC_BASE_MA 12'h064
`define EOC_STEP_MA 12'h019

`endif

// ---- hw/pin_sync3.v ----
// Three-stage pin synchroniser; output moves only when stages 2 and 3 agree
module pin_sync3 #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
    input wire clk,
    input wire rst_b,
    input wire [WIDTH-1:0] asyncIn,
    output wire [WIDTH-1:0] synced
);

    reg [WIDTH-1:0] stage1_reg;
    reg [WIDTH-1:0] stage2_reg;
    reg [WIDTH-1:0] stage3_reg;
    reg [WIDTH-1:0] out_reg;
    integer i;

    always @(posedge clk) begin
        if (!rst_b) begin
            stage1_reg <= RESET_VAL;
            stage2_reg <= RESET_VAL;
            stage3_reg <= RESET_VAL;
            out_reg <= RESET_VAL;
        end else begin
            stage1_reg <= asyncIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            for (i = 0; i < WIDTH; i = i + 1) begin
                if (stage2_reg[i] == stage3_reg[i]) begin
                    out_reg[i] <= stage3_reg[i];
                end
            end
        end
    end

    assign synced = out_reg;

endmodule // pin_sync3

// ---- hw/charger_mask_setpoint_regs.v ----
`include "charger_regs_defs.vh"

module charger_mask_setpoint_regs #(
    // Bus address of the device; value is arbitrary
    parameter [6:0] DEV_ADDR = 7'h2A
) (
    input wire clk,
    input wire rst_b,
    input wire scl,
    input wire sdaIn,
    output wire sdaOut,
    output wire sdaOe,
    input wire offState,
    input wire regResetReq,
    input wire boostHostMode,
    input wire [4:0] chargeEvents,
    input wire [7:1] thermalEvents,
    input wire [3:0] boostEvents,
    input wire [11:0] chargeCurrentMa,
    output wire irqEventPulse,
    output wire eocAboveSense,
    output wire [5:0] chargeVoltageCode,
    output wire [12:0] chargeVoltageMv,
    output wire [2:0] eocThresholdCode,
    output wire [11:0] eocThresholdMa,
    output wire [3:0] chargeCurrentCode
);

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_ADDR = 3'h1;
    localparam [2:0] ST_ACK = 3'h2;
    localparam [2:0] ST_PTR = 3'h3;
    localparam [2:0] ST_WDATA = 3'h4;
    localparam [2:0] ST_RDATA = 3'h5;
    localparam [2:0] ST_RACK = 3'h6;

    function [12:0] voltageMv;
        input [5:0] code;
        begin
            voltageMv = `VSET_BASE_MV + ({7'h00, code} * `VSET_STEP_MV);
        end
    endfunction

    function [11:0] thresholdMa;
        input [2:0] code;
        begin
            thresholdMa = `EOC_BASE_MA + ({9'h000, code} * `EOC_STEP_MA);
        end
    endfunction

    wire [1:0] busSync;
    wire sclS;
    wire sdaS;
    reg sclPrev_reg;
    reg sdaPrev_reg;
    wire sclRise;
    wire sclFall;
    wire startCond;
    wire stopCond;

    reg [2:0] state_reg;
    reg [2:0] afterAck_reg;
    reg [3:0] bitCnt_reg;
    reg [7:0] shift_reg;
    reg [7:0] ptr_reg;
    reg sdaOe_reg;
    reg sdaOut_reg;
    reg [7:0] rdByte;
    wire wrStrobe;

    reg boostPrev_reg;
    wire regClear;

    reg [4:0] chargeMask_reg;
    reg [7:1] thermalMask_reg;
    reg [3:0] boostMask_reg;
    reg [5:0] vsetCode_reg;
    reg [2:0] eocCode_reg;
    reg [3:0] ichgCode_reg;

    reg irqPulse_reg;
    reg eocSense_reg;
    reg [12:0] voltageMv_reg;
    reg [11:0] thresholdMa_reg;

    pin_sync3 #(
        .WIDTH(2),
        .RESET_VAL(2'h3)
    ) uBusSync (
        .clk(clk),
        .rst_b(rst_b),
        .asyncIn({scl, sdaIn}),
        .synced(busSync)
    );

    assign sclS = busSync[1];
    assign sdaS = busSync[0];
    assign sclRise = sclS & ~sclPrev_reg;
    assign sclFall = ~sclS & sclPrev_reg;
    assign startCond = sclS & sclPrev_reg & sdaPrev_reg & ~sdaS;
    assign stopCond = sclS & sclPrev_reg & ~sdaPrev_reg & sdaS;

    always @(posedge clk) begin
        if (!rst_b) begin
            sclPrev_reg <= 1'b1;
            sdaPrev_reg <= 1'b1;
            sdaOut_reg <= 1'b0;
        end else begin
            sclPrev_reg <= sclS;
            sdaPrev_reg <= sdaS;
            sdaOut_reg <= 1'b0;
        end
    end

    // Read mux; unmapped offsets and reserved bits return zero
    always @* begin
        rdByte = 8'h00;
        case (ptr_reg)
            `OFS_CHARGE_EVENT_MASK: rdByte = {3'h0, chargeMask_reg};
            `OFS_THERMAL_TIMEOUT_MASK: rdByte = {thermalMask_reg, 1'b0};
            `OFS_BOOST_EVENT_MASK: rdByte = {4'h0, boostMask_reg};
            `OFS_CHARGE_VOLTAGE_SET: rdByte = {2'h0, vsetCode_reg};
            `OFS_CHARGE_CURRENT_SET:
                rdByte = {1'b0, eocCode_reg, ichgCode_reg};
            default: rdByte = 8'h00;
        endcase
    end

    // Bus slave: address, register pointer, then data with auto-increment
    always @(posedge clk) begin
        if (!rst_b) begin
            state_reg <= ST_IDLE;
            afterAck_reg <= ST_IDLE;
            bitCnt_reg <= 4'h0;
            shift_reg <= 8'h00;
            ptr_reg <= 8'h00;
            sdaOe_reg <= 1'b0;
        end else if (startCond) begin
            state_reg <= ST_ADDR;
            bitCnt_reg <= 4'h0;
            sdaOe_reg <= 1'b0;
        end else if (stopCond) begin
            state_reg <= ST_IDLE;
            sdaOe_reg <= 1'b0;
        end else begin
            case (state_reg)
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (sclRise && bitCnt_reg != 4'h8) begin
                        shift_reg <= {shift_reg[6:0], sdaS};
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (sclFall && bitCnt_reg == 4'h8) begin
                        bitCnt_reg <= 4'h0;
                        if (state_reg == ST_ADDR) begin
                            if (shift_reg[7:1] == DEV_ADDR) begin
                                sdaOe_reg <= 1'b1;
                                state_reg <= ST_ACK;
                                afterAck_reg <= shift_reg[0] ? ST_RDATA
                                                             : ST_PTR;
                            end else begin
                                state_reg <= ST_IDLE;
                            end
                        end else begin
                            sdaOe_reg <= 1'b1;
                            state_reg <= ST_ACK;
                            afterAck_reg <= ST_WDATA;
                            if (state_reg == ST_PTR) begin
                                ptr_reg <= shift_reg;
                            end else begin
                                ptr_reg <= ptr_reg + 8'h01;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        state_reg <= afterAck_reg;
                        bitCnt_reg <= 4'h0;
                        if (afterAck_reg == ST_RDATA) begin
                            shift_reg <= rdByte;
                            sdaOe_reg <= ~rdByte[7];
                            ptr_reg <= ptr_reg + 8'h01;
                        end else begin
                            sdaOe_reg <= 1'b0;
                        end
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_reg <= bitCnt_reg + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_reg == 4'h8) begin
                            sdaOe_reg <= 1'b0;
                            state_reg <= ST_RACK;
                            bitCnt_reg <= 4'h0;
                        end else begin
                            shift_reg <= {shift_reg[6:0], 1'b0};
                            sdaOe_reg <= ~shift_reg[6];
                        end
                    end
                end
                ST_RACK: begin
                    if (sclRise && sdaS) begin
                        state_reg <= ST_IDLE;
                    end else if (sclFall) begin
                        state_reg <= ST_RDATA;
                        shift_reg <= rdByte;
                        sdaOe_reg <= ~rdByte[7];
                        ptr_reg <= ptr_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    assign wrStrobe = (state_reg == ST_WDATA) && sclFall &&
                      (bitCnt_reg == 4'h8) && !startCond && !stopCond;

    // Boost mode entry is its rising edge
    always @(posedge clk) begin
        if (!rst_b) begin
            boostPrev_reg <= 1'b0;
        end else begin
            boostPrev_reg <= boostHostMode;
        end
    end

    assign regClear = offState | regResetReq |
                      (boostHostMode & ~boostPrev_reg);

    // Stored fields only; reserved bits have no storage at all
    always @(posedge clk) begin
        if (!rst_b || regClear) begin
            chargeMask_reg <= `RST_CHARGE_EVENT_MASK;
            thermalMask_reg <= `RST_THERMAL_TIMEOUT_MASK;
            boostMask_reg <= `RST_BOOST_EVENT_MASK;
            vsetCode_reg <= `RST_VOLTAGE_CODE;
            eocCode_reg <= `RST_EOC_CODE;
            ichgCode_reg <= `RST_CHARGE_CURRENT_CODE_CODE;
        end else if (wrStrobe) begin
            case (ptr_reg)
                `OFS_CHARGE_EVENT_MASK:
                    chargeMask_reg <= shift_reg[4:0];
                `OFS_THERMAL_TIMEOUT_MASK:
                    thermalMask_reg <= shift_reg[7:1];
                `OFS_BOOST_EVENT_MASK:
                    boostMask_reg <= shift_reg[3:0];
                `OFS_CHARGE_VOLTAGE_SET: begin
                    // Codes above the top setting are held at the top
                    if (shift_reg[`VSET_MSB:`VSET_LSB] > `VSET_TOP_CODE) begin
                        vsetCode_reg <= `VSET_TOP_CODE;
                    end else begin
                        vsetCode_reg <= shift_reg[`VSET_MSB:`VSET_LSB];
                    end
                end
                `OFS_CHARGE_CURRENT_SET: begin
                    eocCode_reg <= shift_reg[`EOC_MSB:`EOC_LSB];
                    ichgCode_reg <= shift_reg[`CHARGE_CURRENT_CODE_MSB:`CHARGE_CURRENT_CODE_LSB];
                end
                default: begin
                    ichgCode_reg <= ichgCode_reg;
                end
            endcase
        end
    end

    // Scaled setpoints, end of charge compare and masked event request
    always @(posedge clk) begin
        if (!rst_b) begin
            irqPulse_reg <= 1'b0;
            eocSense_reg <= 1'b0;
            voltageMv_reg <= voltageMv(`RST_VOLTAGE_CODE);
            thresholdMa_reg <= thresholdMa(`RST_EOC_CODE);
        end else begin
            irqPulse_reg <= |(chargeEvents & ~chargeMask_reg) |
                            |(thermalEvents & ~thermalMask_reg) |
                            |(boostEvents & ~boostMask_reg);
            eocSense_reg <= chargeCurrentMa >
                            thresholdMa(eocCode_reg);
            voltageMv_reg <= voltageMv(vsetCode_reg);
            thresholdMa_reg <= thresholdMa(eocCode_reg);
        end
    end

    assign sdaOut = sdaOut_reg;
    assign sdaOe = sdaOe_reg;
    assign irqEventPulse = irqPulse_reg;
    assign eocAboveSense = eocSense_reg;
    assign chargeVoltageCode = vsetCode_reg;
    assign chargeVoltageMv = voltageMv_reg;
    assign eocThresholdCode = eocCode_reg;
    assign eocThresholdMa = thresholdMa_reg;
    assign chargeCurrentCode = ichgCode_reg;

endmodule // charger_mask_setpoint_regs

// ---- sim/charger_regs_props.sv ----
module charger_regs_props (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic offState,
    input wire logic regResetReq,
    input wire logic boostHostMode,
    input wire logic [4:0] chargeEvents,
    input wire logic [7:1] thermalEvents,
    input wire logic [3:0] boostEvents,
    input wire logic [11:0] chargeCurrentMa,
    input wire logic irqEventPulse,
    input wire logic eocAboveSense,
    input wire logic [5:0] chargeVoltageCode,
    input wire logic [12:0] chargeVoltageMv,
    input wire logic [2:0] eocThresholdCode,
    input wire logic [11:0] eocThresholdMa,
    input wire logic [3:0] chargeCurrentCode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_defaults;
        chargeVoltageCode == 6'h0C && eocThresholdCode == 3'h2
            && chargeCurrentCode == 4'h6;
    endsequence
    sequence s_quiet;
        chargeEvents == 5'h00 && thermalEvents == 7'h00 && boostEvents == 4'h0;
    endsequence
    a_reset_loads_defaults: assert property (disable iff (1'b0)
        !rst_b |=> s_defaults ##0 (!irqEventPulse && !eocAboveSense))
        else $error("defaults missing after reset");
    a_off_state_defaults: assert property (offState |=> s_defaults)
        else $error("off state did not restore defaults");
    a_reg_reset_defaults: assert property (regResetReq |=> s_defaults)
        else $error("register reset did not restore defaults");
    a_boost_entry_defaults: assert property (
        $rose(boostHostMode) |-> ##[1:2] s_defaults)
        else $error("boost entry did not restore defaults");
    a_voltage_mv_scale: assert property (
        chargeVoltageMv == 13'hCE4 + 13'h19 * $past(chargeVoltageCode))
        else $error("voltage millivolts wrong");
    a_eoc_ma_scale: assert property (
        eocThresholdMa == 12'h064 + 12'h019 * $past(eocThresholdCode))
        else $error("end of charge milliamps wrong");
    a_voltage_code_top: assert property (chargeVoltageCode <= 6'h30)
        else $error("voltage code above top");
    a_sense_vs_thresh: assert property (
        $stable(eocThresholdMa) && $stable(eocThresholdCode)
        |=> eocAboveSense == ($past(chargeCurrentMa) > $past(eocThresholdMa)))
        else $error("end of charge sense wrong");
    a_quiet_no_irq: assert property (s_quiet |=> !irqEventPulse)
        else $error("interrupt without event");
    a_state_change_irq: assert property (
        offState && $past(offState) && chargeEvents[0] |=> irqEventPulse)
        else $error("unmasked state change gave no interrupt");
endmodule // charger_regs_props

bind charger_mask_setpoint_regs charger_regs_props props (.clk, .rst_b,
    .offState, .regResetReq, .boostHostMode, .chargeEvents, .thermalEvents,
    .boostEvents, .chargeCurrentMa, .irqEventPulse, .eocAboveSense,
    .chargeVoltageCode, .chargeVoltageMv, .eocThresholdCode, .eocThresholdMa,
    .chargeCurrentCode);

// ---- sim/i2c_host_model.sv ----
// Bus controller; every phase lasts at least five clocks
module i2c_host_model (
    input wire logic clk,
    input wire logic sda,
    output logic scl,
    output logic sdaDrv
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        scl = 1'b1;
        sdaDrv = 1'b1;
    end
    task automatic waitQ();
        repeat (5) @(posedge clk);
    endtask
    task automatic bitOut(input logic b);
        sdaDrv <= b;
        waitQ();
        scl <= 1'b1;
        waitQ();
        waitQ();
        scl <= 1'b0;
        waitQ();
    endtask
    task automatic bitIn(output logic b);
        sdaDrv <= 1'b1;
        waitQ();
        scl <= 1'b1;
        waitQ();
        b = sda;
        waitQ();
        scl <= 1'b0;
        waitQ();
    endtask
    task automatic start();
        sdaDrv <= 1'b1;
        waitQ();
        scl <= 1'b1;
        waitQ();
        sdaDrv <= 1'b0;
        waitQ();
        scl <= 1'b0;
        waitQ();
    endtask
    task automatic stop();
        sdaDrv <= 1'b0;
        waitQ();
        scl <= 1'b1;
        waitQ();
        sdaDrv <= 1'b1;
        waitQ();
    endtask
    task automatic byteOut(input logic [7:0] d, output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) bitOut(d[i]);
        bitIn(b);
        ack = !b;
    endtask
    task automatic byteIn(output logic [7:0] d, input logic last);
        for (int i = 7; i >= 0; i--) bitIn(d[i]);
        bitOut(last);
    endtask
endmodule // i2c_host_model

// ---- sim/tb_charger_mask_setpoint_regs.sv ----
module tb_charger_mask_setpoint_regs;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [6:0] DEV = 7'h2A;
    localparam logic [7:0] RSTV [5] = '{8'h00, 8'h0E, 8'h0F, 8'h0C, 8'h26};
    localparam logic [7:0] FFV [5] = '{8'h1F, 8'hFE, 8'h0F, 8'h30, 8'h7F};
    logic clk, rst_b, offState, regResetReq, boostHostMode;
    logic [4:0] chargeEvents;
    logic [7:1] thermalEvents;
    logic [3:0] boostEvents;
    logic [11:0] chargeCurrentMa, eocThresholdMa;
    logic irqEventPulse, eocAboveSense, sdaOut, sdaOe, scl, sdaDrv;
    logic [5:0] chargeVoltageCode;
    logic [12:0] chargeVoltageMv;
    logic [2:0] eocThresholdCode;
    logic [3:0] chargeCurrentCode;
    logic [7:0] rd;
    int fail_count = 0;
    int n_compared = 0;
    int cycles = 0;
    // Open-drain line with pull-up
    wire sda = sdaOe ? sdaOut : sdaDrv;
    charger_mask_setpoint_regs #(.DEV_ADDR(DEV)) dut (.clk, .rst_b, .scl,
        .sdaIn(sda), .sdaOut, .sdaOe, .offState, .regResetReq, .boostHostMode,
        .chargeEvents, .thermalEvents, .boostEvents, .chargeCurrentMa,
        .irqEventPulse, .eocAboveSense, .chargeVoltageCode, .chargeVoltageMv,
        .eocThresholdCode, .eocThresholdMa, .chargeCurrentCode);
    i2c_host_model host (.clk, .sda, .scl, .sdaDrv);
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [12:0] exp,
                         input logic [12:0] got);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic regWrite(input logic [7:0] ofs, input logic [7:0] val);
        logic a0, a1, a2;
        host.start();
        host.byteOut({DEV, 1'b0}, a0);
        host.byteOut(ofs, a1);
        host.byteOut(val, a2);
        host.stop();
        check("write ack", 13'h1, {12'h0, a0 & a1 & a2});
    endtask
    task automatic chkReg(input logic [7:0] ofs, input logic [7:0] exp);
        logic a0, a1, a2;
        host.start();
        host.byteOut({DEV, 1'b0}, a0);
        host.byteOut(ofs, a1);
        host.start();
        host.byteOut({DEV, 1'b1}, a2);
        host.byteIn(rd, 1'b1);
        host.stop();
        check("read ack", 13'h1, {12'h0, a0 & a1 & a2});
        check("register", {5'h0, exp}, {5'h0, rd});
    endtask
    task automatic evt(input logic [4:0] ce, input logic [7:1] te,
                       input logic [3:0] be, input logic exp);
        @(posedge clk);
        chargeEvents <= ce;
        thermalEvents <= te;
        boostEvents <= be;
        @(posedge clk);
        chargeEvents <= 5'h00;
        thermalEvents <= 7'h00;
        boostEvents <= 4'h0;
        #1 check("irq", {12'h0, exp}, {12'h0, irqEventPulse});
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 32'h0000_EA60) begin
            fail_count++;
            end_of_test();
        end
    end
    initial begin
        rst_b = 1'b0;
        offState = 1'b0;
        regResetReq = 1'b0;
        boostHostMode = 1'b0;
        chargeEvents = 5'h00;
        thermalEvents = 7'h00;
        boostEvents = 4'h0;
        chargeCurrentMa = 12'h000;
        repeat (8) @(posedge clk);
        rst_b <= 1'b1;
        for (int i = 0; i < 5; i++) begin
            chkReg(8'(8'h0B + i), RSTV[i]);
        end
        check("mv", 13'hE10, chargeVoltageMv);
        check("ma", 13'h096, {1'b0, eocThresholdMa});
        chkReg(8'h20, 8'h00);
        evt(5'h01, 7'h00, 4'h0, 1'b1);
        evt(5'h10, 7'h00, 4'h0, 1'b1);
        evt(5'h00, 7'h07, 4'h0, 1'b0);
        evt(5'h00, 7'h40, 4'h0, 1'b1);
        evt(5'h00, 7'h00, 4'hF, 1'b0);
        for (int i = 0; i < 5; i++) begin
            regWrite(8'(8'h0B + i), 8'hFF);
        end
        for (int i = 0; i < 5; i++) begin
            chkReg(8'(8'h0B + i), FFV[i]);
        end
        check("mv", 13'h1194, chargeVoltageMv);
        check("ma", 13'h113, {1'b0, eocThresholdMa});
        evt(5'h1F, 7'h7F, 4'hF, 1'b0);
        regWrite(8'h0B, 8'h1E);
        evt(5'h01, 7'h00, 4'h0, 1'b1);
        evt(5'h10, 7'h00, 4'h0, 1'b0);
        // Unmask the timeouts and one boost event to reach those paths
        regWrite(8'h0C, 8'hF1);
        regWrite(8'h0D, 8'h0E);
        chkReg(8'h0C, 8'hF0);
        evt(5'h00, 7'h01, 4'h0, 1'b1);
        evt(5'h00, 7'h70, 4'h0, 1'b0);
        evt(5'h00, 7'h00, 4'h1, 1'b1);
        evt(5'h00, 7'h00, 4'h8, 1'b0);
        regWrite(8'h0E, 8'h00);
        regWrite(8'h0F, 8'h05);
        check("mv", 13'hCE4, chargeVoltageMv);
        check("ma", 13'h064, {1'b0, eocThresholdMa});
        check("charge_current_code", 13'h005, {9'h000, chargeCurrentCode});
        @(posedge clk) chargeCurrentMa <= 12'h065;
        repeat (2) @(posedge clk);
        #1 check("sense", 13'h1, {12'h0, eocAboveSense});
        @(posedge clk) chargeCurrentMa <= 12'h064;
        repeat (2) @(posedge clk);
        #1 check("sense", 13'h0, {12'h0, eocAboveSense});
        @(posedge clk) regResetReq <= 1'b1;
        @(posedge clk) regResetReq <= 1'b0;
        chkReg(8'h0E, 8'h0C);
        chkReg(8'h0B, 8'h00);
        regWrite(8'h0E, 8'h20);
        check("mv", 13'h1004, chargeVoltageMv);
        @(posedge clk) offState <= 1'b1;
        evt(5'h01, 7'h00, 4'h0, 1'b1);
        check("vcode", 13'h00C, {7'h00, chargeVoltageCode});
        @(posedge clk) offState <= 1'b0;
        regWrite(8'h0E, 8'h20);
        regWrite(8'h0F, 8'h11);
        @(posedge clk) boostHostMode <= 1'b1;
        repeat (3) @(posedge clk);
        #1 check("vcode", 13'h00C, {7'h00, chargeVoltageCode});
        check("eoc", 13'h002, {10'h000, eocThresholdCode});
        check("charge_current_code", 13'h006, {9'h000, chargeCurrentCode});
        @(posedge clk) boostHostMode <= 1'b0;
        // Power-on reset again in mid-run, then the bus must still answer
        regWrite(8'h0E, 8'h20);
        @(posedge clk) rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        #1 check("vcode", 13'h00C, {7'h00, chargeVoltageCode});
        check("mv", 13'hE10, chargeVoltageMv);
        chkReg(8'h0E, 8'h0C);
        end_of_test();
    end
endmodule // tb_charger_mask_setpoint_regs
